// *** timestamp_irq_and_buffer_bench.sv ***
// Self-checking bench for the timestamp buffer core
`timescale 1ns/10ps
module timestamp_irq_and_buffer_bench;
  import tsib_pkg::*;
  logic ref_clk, srst, reg_we, reg_re, reg_rvalid, ts_valid, ts_ready, conv_err_flag;
  logic sync_enable, acquisition_start_pulse, acq_active, pll_cfg_busy, irq_req, send;
  logic [19:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rs, t;
  logic [TS_W-1:0] ts_data, send_data;
  logic [TS_W-1:0] mem [BUF_DEPTH];
  logic [SYNC_ST_W-1:0] sync_status;
  logic [CMD_W-1:0] cmd_pulse;
  logic [4:0] drop;
  logic [2:0] pend;
  int stored, since, thr, wbase, failures, comparisons, i, n, k;

  tsib_core #(.MS_CYCLES(10), .SEC_CYCLES(50000), .PLL_CFG_CYCLES(20)) dut_u (.ref_clk,
    .srst, .reg_addr, .reg_we, .reg_wdata, .reg_re, .reg_rdata, .reg_rvalid, .ts_valid,
    .ts_data, .ts_ready, .conv_err_flag, .sync_status, .sync_enable,
    .acquisition_start_pulse, .cmd_pulse, .acq_active, .pll_cfg_busy, .irq_req);
  tsib_conv_model conv_u (.ref_clk, .srst, .send, .send_data, .ts_ready, .ts_valid,
    .ts_data);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  function logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wr(input logic [19:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge ref_clk);
    reg_we = 1'b0;
  endtask : wr
  task rc(input string nm, input logic [19:0] a, input logic [31:0] e);
    @(negedge ref_clk);
    reg_addr = a;
    reg_re = 1'b1;
    @(negedge ref_clk);
    reg_re = 1'b0;
    chk(nm, e, reg_rvalid === 1'b1 ? reg_rdata : 32'hx);
  endtask : rc
  task rpos();
    repeat (4) @(negedge ref_clk);
    rc("write_position", A_WR_POS, 32'((stored / 256 - wbase) * 4096 + (stored % 256) * 16));
  endtask : rpos
  task tsend(input logic [2:0] ch, input bit must);
    int w;
    t = rnd();
    @(negedge ref_clk);
    send_data = {ch, t[28:0], rnd(), rnd(), rnd()};
    send = 1'b1;
    @(negedge ref_clk);
    send = 1'b0;
    for (w = 0; w < 50 && ts_valid; w++) @(negedge ref_clk);
    if (must && ts_valid) chk("accept_timeout", 0, 1);
    if (!drop[ch]) begin
      mem[stored % 256] = send_data;
      stored++;
      since++;
      if (since > thr) begin
        pend[0] = 1'b1;
        since = 0;
      end
    end
  endtask : tsend
  task end_of_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {reg_we, reg_re, send, conv_err_flag, drop, pend} = '0;
    {reg_addr, reg_wdata, send_data, sync_status} = '0;
    {stored, since, wbase, failures, comparisons} = '0;
    rs = 32'h00000043;
    thr = 255;
    srst = 1'b1;
    repeat (10) @(negedge ref_clk);
    srst = 1'b0;
    chk("acq_active", 0, acq_active);
    rc("count_threshold", A_CNT_THR, 32'h000000FF);
    rc("time_threshold", A_TIME_THR, 32'h000000C8);
    rc("drop_mask", A_CH_DROP, 0);
    rc("pending", A_IRQ_PEND, 0);
    rc("command", A_CMD, 0);
    rc("unmapped", 20'h51FF0, 0);
    for (i = 0; i < 100 && pll_cfg_busy; i++) @(negedge ref_clk);
    chk("pll_busy", 0, pll_cfg_busy);
    wr(A_IRQ_EN, 7);
    rc("enabled", A_IRQ_VIEW, 7);
    wr(A_IRQ_DIS, 2);
    wr(A_IRQ_EN, 0);
    wr(A_IRQ_DIS, 0);
    rc("enabled", A_IRQ_VIEW, 5);
    t = rnd();
    sync_status = t[9:0];
    wr(A_SYNC_CTRL, 1);
    rc("sync_status", A_SYNC_STAT, {22'h0, sync_status});
    thr = 2;
    drop = 5'h02;
    wr(A_CNT_THR, 2);
    wr(A_CH_DROP, 2);
    wr(A_CMD, 32'h4);
    wr(A_CMD, 1);
    for (i = 0; i < 5; i++) tsend(3'(i), 1);
    rpos();
    for (n = 0; n < stored; n++)
      for (k = 0; k < 4; k++)
        rc("entry", 20'(A_BUF_BASE + 16 * n + 4 * k), mem[n][32 * k +: 32]);
    rc("pending", A_IRQ_PEND, {29'h0, pend});
    wr(A_IRQ_PEND, 0);
    rc("pending", A_IRQ_PEND, {29'h0, pend});
    wr(A_IRQ_PEND, 7);
    pend = 3'h0;
    rc("pending", A_IRQ_PEND, 0);
    wr(A_TIME_THR, 1);
    repeat (40) @(negedge ref_clk);
    pend[1] = 1'b1;
    rc("pending", A_IRQ_PEND, {29'h0, pend});
    chk("irq_req", 0, irq_req);
    wr(A_IRQ_EN, 2);
    repeat (2) @(negedge ref_clk);
    chk("irq_req", 1, irq_req);
    wr(A_IRQ_PEND, 2);
    conv_err_flag = 1'b1;
    repeat (8) @(negedge ref_clk);
    pend = 3'h4;
    rc("pending", A_IRQ_PEND, {29'h0, pend});
    wr(A_IRQ_PEND, 7);
    rc("pending", A_IRQ_PEND, 0);
    chk("irq_req", 0, irq_req);
    t = rnd();
    wr(A_START_UTC, t);
    wr(A_CMD, 32'h200);
    rc("utc", A_CUR_UTC, t);
    for (i = 0; i < 252; i++) tsend(0, 1);
    rpos();
    wr(A_CMD, 32'h400);
    wbase = stored / 256;
    rpos();
    wr(A_CMD, 2);
    chk("acq_active", 0, acq_active);
    for (i = 0; i < 17; i++) tsend(0, i < 16);
    chk("ts_ready", 0, ts_ready);
    wr(A_CMD, 1);
    repeat (20) @(negedge ref_clk);
    rpos();
    wr(A_IRQ_DIS, 7);
    rc("enabled", A_IRQ_VIEW, 0);
    end_of_test();
  end
endmodule : timestamp_irq_and_buffer_bench

// *** tsib_checker.sv ***
// Port-level assertions for the timestamp buffer core
`timescale 1ns/10ps
module tsib_checker
  import tsib_pkg::*;
#(parameter int PLL_CFG_CYCLES = PLL_CFG_CYC) (
  input wire logic             ref_clk,                 // Clock
  input wire logic             srst,                    // Reset
  input wire logic [19:0]      reg_addr,                // Address
  input wire logic             reg_we,                  // Write
  input wire logic [31:0]      reg_wdata,               // Write data
  input wire logic             reg_re,                  // Read
  input wire logic [31:0]      reg_rdata,               // Read data
  input wire logic             conv_err_flag,           // Error pin
  input wire logic             sync_enable,             // Sync start
  input wire logic             acquisition_start_pulse, // Start pulse
  input wire logic [CMD_W-1:0] cmd_pulse,               // Commands
  input wire logic             acq_active,              // Running
  input wire logic             pll_cfg_busy,            // PLL setup
  input wire logic             irq_req                  // Request
);
  logic [2:0]  en_ff;
  logic [15:0] age_ff;

  // Shadow of the source enables
  always_ff @(posedge ref_clk) begin
    if (srst) en_ff <= 3'h0;
    else if (reg_we && reg_addr == A_IRQ_DIS) en_ff <= en_ff & ~reg_wdata[2:0];
    else if (reg_we && reg_addr == A_IRQ_EN) en_ff <= en_ff | reg_wdata[2:0];
  end

  always_ff @(posedge ref_clk) begin
    if (srst) age_ff <= 16'h0000;
    else if (age_ff != 16'hFFFF) age_ff <= age_ff + 16'h0001;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_cmd_echo: assert property (reg_we && reg_addr == A_CMD
    |=> cmd_pulse == $past(reg_wdata[CMD_W-1:0])) else $error("command echo wrong");
  a_cmd_self_clear: assert property (!(reg_we && reg_addr == A_CMD)
    |=> cmd_pulse == 0) else $error("command not cleared");
  a_start_pulse: assert property (reg_we && reg_addr == A_CMD && reg_wdata[0]
    && !acq_active |=> acquisition_start_pulse && acq_active) else $error("no start pulse");
  a_dis_masks_irq: assert property (reg_we && reg_addr == A_IRQ_DIS
    && reg_wdata[2:0] == 3'h7 |=> ##1 !irq_req) else $error("request not masked");
  a_view_reads_en: assert property (reg_re && reg_addr == A_IRQ_VIEW
    |=> reg_rdata == {29'h0, en_ff}) else $error("enable view wrong");
  a_sync_follows: assert property (reg_we && reg_addr == A_SYNC_CTRL
    |=> sync_enable == $past(reg_wdata[0])) else $error("sync enable wrong");
  a_err_raises_irq: assert property ($rose(conv_err_flag) && en_ff[2]
    |-> ##[3:8] irq_req) else $error("error request missing");
  a_pos_aligned: assert property (reg_re && reg_addr == A_WR_POS
    |=> reg_rdata[3:0] == 4'h0) else $error("position not aligned");
  a_pll_busy_holds: assert property (age_ff < PLL_CFG_CYCLES - 1
    |-> pll_cfg_busy) else $error("PLL setup ended early");
  a_pll_busy_ends: assert property (age_ff > PLL_CFG_CYCLES + 1
    |-> !pll_cfg_busy) else $error("PLL setup too long");
endmodule : tsib_checker

bind tsib_core tsib_checker #(.PLL_CFG_CYCLES(PLL_CFG_CYCLES)) chk_u (.ref_clk, .srst,
  .reg_addr, .reg_we, .reg_wdata, .reg_re, .reg_rdata, .conv_err_flag, .sync_enable,
  .acquisition_start_pulse, .cmd_pulse, .acq_active, .pll_cfg_busy, .irq_req);

// *** tsib_conv_model.sv ***
// Converter model: offers one timestamp per request
`timescale 1ns/10ps
module tsib_conv_model (
  input  wire logic         ref_clk,   // Core clock
  input  wire logic         srst,      // Reset
  input  wire logic         send,      // New timestamp request
  input  wire logic [127:0] send_data, // Timestamp to offer
  input  wire logic         ts_ready,  // Core accepts
  output logic              ts_valid,  // Offer pending
  output logic      [127:0] ts_data    // Offered word
);
  logic         valid_ff;
  logic [127:0] held_ff;

  // Emits every hit, deactivated channels too
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      valid_ff <= 1'b0;
    end else if (send) begin
      valid_ff <= 1'b1;
    end else if (valid_ff && ts_ready) begin
      valid_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (send) begin
      held_ff <= send_data;
    end
  end

  // Released bus shows the inverse of the last word
  assign ts_valid = valid_ff;
  assign ts_data  = valid_ff ? held_ff : ~held_ff;
endmodule : tsib_conv_model

// *** tsib_core.sv ***
// Timestamp buffer, time base, command register and interrupt gatherer
//
// Contract
// - Timestamps of deactivated channels are dropped before the circular buffer.
// - Command register is one-hot, acted on at write, always reads zero.
// - Write position: low 12 bits next byte position, high 20 bits wrap count.
// - Command bit 9 reloads seconds time base from start value, even while running.
// - Count interrupt when timestamps since last event exceed count threshold.
// - Time interrupt when ms since last event exceed threshold and data exists.
// - Error interrupt when converter error flag rises.
// - Three sources merged into one maskable request upstream.
// - Writing one to disable register disables that source; zero no effect.
// - Writing one to enable register enables that source; zero no effect.
// - Enabled view reads one per enabled source.
// - Pending flags read one while pending; write one clears.
// - Bit 0 count, bit 1 time, bit 2 error in all interrupt registers.
// - 128-bit entries readable at buffer base; position counts bytes, 16 per entry.
// - After reset the main state machine is inactive.
// - Acquisition start pulses the converter and buffers every timestamp of an active (not dropped) channel.
// - Sync control bit 0 starts synchronisation; status bit 4 shows lock.
// - Count threshold defaults to full buffer, time threshold to 200 ms.
// - Count threshold is 8 bits, reset 0xFF.
// - Time threshold is 32-bit milliseconds, reset 0xC8.
// - Drop bits 0..4 map to channels 0..4, all active at reset.
`timescale 1ns/10ps
module tsib_core
  import tsib_pkg::*;
#(
  parameter int MS_CYCLES      = MS_CYC,
  parameter int SEC_CYCLES     = SEC_CYC,
  parameter int PLL_CFG_CYCLES = PLL_CFG_CYC
) (
  input  wire logic                 ref_clk,        // 25 MHz core clock
  input  wire logic                 srst,           // Synchronous reset, active high
  input  wire logic [19:0]          reg_addr,       // Register byte address
  input  wire logic                 reg_we,         // Register write strobe
  input  wire logic [31:0]          reg_wdata,      // Register write data
  input  wire logic                 reg_re,         // Register read strobe
  output logic      [31:0]          reg_rdata,      // Register read data
  output logic                      reg_rvalid,     // Read data valid pulse
  input  wire logic                 ts_valid,       // Formatted timestamp valid
  input  wire logic [TS_W-1:0]      ts_data,        // Formatted timestamp
  output logic                      ts_ready,       // Timestamp accepted
  input  wire logic                 conv_err_flag,  // Converter error flag pin
  input  wire logic [SYNC_ST_W-1:0] sync_status,    // Network sync status pins
  output logic                      sync_enable,    // Network sync start
  output logic                      acquisition_start_pulse, // Converter start
  output logic      [CMD_W-1:0]     cmd_pulse,      // Command strobes to core FSMs
  output logic                      acq_active,     // Acquisition running
  output logic                      pll_cfg_busy,   // Mezzanine PLL setup running
  output logic                      irq_req         // Merged interrupt request
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [TS_W-1:0]      buf_mem [BUF_DEPTH];
  tsib_state_t          state_ff;
  logic [31:0]          start_utc_ff;
  logic [31:0]          cur_utc_ff;
  logic [7:0]           cnt_thr_ff;
  logic [31:0]          time_thr_ff;
  logic [N_CH-1:0]      ch_drop_ff;
  logic                 sync_en_ff;
  logic [BUF_AW-1:0]    wr_idx_ff;
  logic [WRAP_W-1:0]    wrap_ff;
  logic [IRQ_N-1:0]     irq_en_ff;
  logic [IRQ_N-1:0]     irq_pend_ff;
  logic                 irq_req_ff;
  logic [31:0]          ms_div_ff;
  logic [31:0]          sec_div_ff;
  logic [31:0]          ms_since_ff;
  logic [CNT_W-1:0]     ts_since_ff;
  logic [31:0]          pll_cnt_ff;
  logic                 pll_busy_ff;
  logic                 err_s1_ff;
  logic                 err_s2_ff;
  logic                 err_d_ff;
  logic [SYNC_ST_W-1:0] st_s1_ff;
  logic [SYNC_ST_W-1:0] st_s2_ff;
  logic                 acq_start_ff;
  logic [CMD_W-1:0]     cmd_ff;
  logic [31:0]          rdata_ff;
  logic                 rvalid_ff;
  logic                 cmd_wr;
  logic [CMD_W-1:0]     cmd;
  logic                 ms_tick;
  logic                 sec_tick;
  logic                 pop;
  logic                 drop;
  logic                 store;
  logic                 cnt_evt;
  logic                 time_evt;
  logic                 err_evt;
  logic [IRQ_N-1:0]     irq_set;
  logic [IRQ_N-1:0]     irq_clr;
  logic [2:0]           ch_idx;

  tsib_stream_if #(.W(TS_W)) stream ();

  function automatic logic hit(input logic [19:0] a, input logic [19:0] target);
    hit = (a == target);
  endfunction : hit

  // ----------------------------------------------------------------
  // Input FIFO and input synchronisers
  // ----------------------------------------------------------------
  tsib_fifo #(.W(TS_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk (ref_clk),
    .srst    (srst),
    .s       (stream.fifo_side)
  );

  assign stream.in_valid  = ts_valid;
  assign stream.in_data   = ts_data;
  assign stream.out_ready = (state_ff == ST_ACTIVE);
  assign ts_ready         = stream.in_ready;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      err_s1_ff <= 1'b0;
      err_s2_ff <= 1'b0;
      err_d_ff  <= 1'b0;
      st_s1_ff  <= '0;
      st_s2_ff  <= '0;
    end else begin
      err_s1_ff <= conv_err_flag;
      err_s2_ff <= err_s1_ff;
      err_d_ff  <= err_s2_ff;
      st_s1_ff  <= sync_status;
      st_s2_ff  <= st_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // PLL configuration window after reset
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pll_cnt_ff  <= '0;
      pll_busy_ff <= 1'b1;
    end else if (pll_busy_ff) begin
      if (pll_cnt_ff >= 32'(PLL_CFG_CYCLES - 1)) begin
        pll_busy_ff <= 1'b0;
      end else begin
        pll_cnt_ff <= pll_cnt_ff + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command register and main state machine
  // ----------------------------------------------------------------
  assign cmd_wr = reg_we && hit(reg_addr, A_CMD);
  assign cmd    = cmd_wr ? reg_wdata[CMD_W-1:0] : '0;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_ff     <= ST_INACTIVE;
      acq_start_ff <= 1'b0;
      cmd_ff       <= '0;
    end else begin
      cmd_ff       <= cmd;
      acq_start_ff <= 1'b0;
      case (state_ff)
        ST_INACTIVE: begin
          if (cmd[CMD_ACQ_ON]) begin
            state_ff     <= ST_ACTIVE;
            acq_start_ff <= 1'b1;
          end
        end
        ST_ACTIVE: begin
          if (cmd[CMD_ACQ_OFF]) begin
            state_ff <= ST_INACTIVE;
          end
        end
        default: begin
          state_ff <= ST_INACTIVE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      start_utc_ff <= '0;
      cnt_thr_ff   <= CNT_THR_RST;
      time_thr_ff  <= TIME_THR_RST;
      ch_drop_ff   <= CH_DROP_RST;
      sync_en_ff   <= 1'b0;
    end else if (reg_we) begin
      if (hit(reg_addr, A_START_UTC)) begin
        start_utc_ff <= reg_wdata;
      end
      if (hit(reg_addr, A_CNT_THR)) begin
        cnt_thr_ff <= reg_wdata[7:0];
      end
      if (hit(reg_addr, A_TIME_THR)) begin
        time_thr_ff <= reg_wdata;
      end
      if (hit(reg_addr, A_CH_DROP)) begin
        ch_drop_ff <= reg_wdata[N_CH-1:0];
      end
      if (hit(reg_addr, A_SYNC_CTRL)) begin
        sync_en_ff <= reg_wdata[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Time base: millisecond tick and running seconds
  // ----------------------------------------------------------------
  assign ms_tick  = (ms_div_ff >= 32'(MS_CYCLES - 1));
  assign sec_tick = (sec_div_ff >= 32'(SEC_CYCLES - 1));

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ms_div_ff  <= '0;
      sec_div_ff <= '0;
      cur_utc_ff <= '0;
    end else begin
      ms_div_ff <= ms_tick ? 32'h0 : ms_div_ff + 32'h1;
      if (cmd[CMD_LD_UTC]) begin
        sec_div_ff <= '0;
        cur_utc_ff <= start_utc_ff;
      end else begin
        sec_div_ff <= sec_tick ? 32'h0 : sec_div_ff + 32'h1;
        if (sec_tick) begin
          cur_utc_ff <= cur_utc_ff + 32'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel filter and circular buffer
  // ----------------------------------------------------------------
  assign pop    = stream.out_valid && stream.out_ready;
  assign ch_idx = stream.out_data[CH_MSB:CH_LSB];
  assign drop   = (ch_idx < 3'(N_CH)) && ch_drop_ff[ch_idx];
  assign store  = pop && !drop;

  always_ff @(posedge ref_clk) begin
    if (store) begin
      buf_mem[wr_idx_ff] <= stream.out_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_idx_ff <= '0;
      wrap_ff   <= '0;
    end else begin
      if (store) begin
        wr_idx_ff <= wr_idx_ff + 1'b1;
      end
      if (cmd[CMD_CLR_WRP]) begin
        wrap_ff <= '0;
      end else if (store && (wr_idx_ff == BUF_AW'(BUF_DEPTH - 1))) begin
        wrap_ff <= wrap_ff + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt sources and interval counters
  // ----------------------------------------------------------------
  assign cnt_evt  = (state_ff == ST_ACTIVE) && (ts_since_ff > {1'b0, cnt_thr_ff});
  assign time_evt = (state_ff == ST_ACTIVE) && (ms_since_ff > time_thr_ff)
                    && (ts_since_ff != '0);
  assign err_evt  = err_s2_ff && !err_d_ff;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ts_since_ff <= '0;
      ms_since_ff <= '0;
    end else if (acq_start_ff || cnt_evt || time_evt) begin
      ts_since_ff <= '0;
      ms_since_ff <= '0;
    end else begin
      if (store && (ts_since_ff != '1)) begin
        ts_since_ff <= ts_since_ff + 1'b1;
      end
      if (ms_tick && (ms_since_ff != '1)) begin
        ms_since_ff <= ms_since_ff + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt registers and merged request
  // ----------------------------------------------------------------
  always_comb begin
    irq_set           = '0;
    irq_set[IRQ_CNT]  = cnt_evt;
    irq_set[IRQ_TIME] = time_evt;
    irq_set[IRQ_ERR]  = err_evt;
    irq_clr = (reg_we && hit(reg_addr, A_IRQ_PEND)) ? reg_wdata[IRQ_N-1:0] : '0;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_en_ff   <= IRQ_EN_RST;
      irq_pend_ff <= '0;
      irq_req_ff  <= 1'b0;
    end else begin
      if (reg_we && hit(reg_addr, A_IRQ_EN)) begin
        irq_en_ff <= irq_en_ff | reg_wdata[IRQ_N-1:0];
      end else if (reg_we && hit(reg_addr, A_IRQ_DIS)) begin
        irq_en_ff <= irq_en_ff & ~reg_wdata[IRQ_N-1:0];
      end
      irq_pend_ff <= irq_set | (irq_pend_ff & ~irq_clr);
      irq_req_ff  <= |(irq_pend_ff & irq_en_ff);
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_ff  <= '0;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_re;
      rdata_ff  <= '0;
      if (reg_re) begin
        if (reg_addr >= A_BUF_BASE && reg_addr <= A_BUF_LAST) begin
          rdata_ff <= buf_mem[reg_addr[11:4]][reg_addr[3:2]*32 +: 32];
        end else if (hit(reg_addr, A_START_UTC)) begin
          rdata_ff <= start_utc_ff;
        end else if (hit(reg_addr, A_CNT_THR)) begin
          rdata_ff <= {24'h000000, cnt_thr_ff};
        end else if (hit(reg_addr, A_TIME_THR)) begin
          rdata_ff <= time_thr_ff;
        end else if (hit(reg_addr, A_CH_DROP)) begin
          rdata_ff <= {27'h0000000, ch_drop_ff};
        end else if (hit(reg_addr, A_CUR_UTC)) begin
          rdata_ff <= cur_utc_ff;
        end else if (hit(reg_addr, A_WR_POS)) begin
          rdata_ff <= {wrap_ff, wr_idx_ff, ENTRY_LOG'(0)};
        end else if (hit(reg_addr, A_SYNC_CTRL)) begin
          rdata_ff <= {31'h00000000, sync_en_ff};
        end else if (hit(reg_addr, A_SYNC_STAT)) begin
          rdata_ff <= {22'h000000, st_s2_ff};
        end else if (hit(reg_addr, A_IRQ_VIEW)) begin
          rdata_ff <= {29'h00000000, irq_en_ff};
        end else if (hit(reg_addr, A_IRQ_PEND)) begin
          rdata_ff <= {29'h00000000, irq_pend_ff};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata               = rdata_ff;
  assign reg_rvalid              = rvalid_ff;
  assign sync_enable             = sync_en_ff;
  assign acquisition_start_pulse = acq_start_ff;
  assign cmd_pulse               = cmd_ff;
  assign acq_active              = (state_ff == ST_ACTIVE);
  assign pll_cfg_busy            = pll_busy_ff;
  assign irq_req                 = irq_req_ff;

endmodule : tsib_core

// *** tsib_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module tsib_fifo #(
  parameter int W     = 128,
  parameter int DEPTH = 16
) (
  input wire logic       ref_clk, // Core clock
  input wire logic       srst,    // Synchronous reset
  tsib_stream_if.fifo_side s      // Stream ports
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0]   cnt_ff;
  logic [AW:0]   nxt_cnt;
  logic          in_ready_ff;
  logic          push;
  logic          pop;

  assign push        = s.in_valid & in_ready_ff;
  assign pop         = s.out_ready & (cnt_ff != '0);
  assign s.in_ready  = in_ready_ff;
  assign s.out_valid = (cnt_ff != '0);
  assign s.out_data  = mem[rd_ptr_ff];

  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= s.in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_ptr_ff   <= '0;
      rd_ptr_ff   <= '0;
      cnt_ff      <= '0;
      in_ready_ff <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      cnt_ff      <= nxt_cnt;
      in_ready_ff <= (nxt_cnt != FULL_CNT);
    end
  end
endmodule : tsib_fifo

// *** tsib_pkg.sv ***
// Constants, register map and types for the timestamp interrupt and buffer block
package tsib_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [19:0] A_START_UTC = 20'h51080;
  localparam logic [19:0] A_CNT_THR   = 20'h51090;
  localparam logic [19:0] A_TIME_THR  = 20'h51094;
  localparam logic [19:0] A_CH_DROP   = 20'h5109C;
  localparam logic [19:0] A_CUR_UTC   = 20'h510A0;
  localparam logic [19:0] A_WR_POS    = 20'h510A8;
  localparam logic [19:0] A_SYNC_CTRL = 20'h510B0;
  localparam logic [19:0] A_SYNC_STAT = 20'h510B4;
  localparam logic [19:0] A_CMD       = 20'h510FC;
  localparam logic [19:0] A_IRQ_DIS   = 20'h52000;
  localparam logic [19:0] A_IRQ_EN    = 20'h52004;
  localparam logic [19:0] A_IRQ_VIEW  = 20'h52008;
  localparam logic [19:0] A_IRQ_PEND  = 20'h5200C;
  localparam logic [19:0] A_BUF_BASE  = 20'h54000;
  localparam logic [19:0] A_BUF_LAST  = 20'h54FFF;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CNT_THR_RST  = 8'hFF;
  localparam logic [31:0] TIME_THR_RST = 32'h000000C8;
  localparam logic [4:0]  CH_DROP_RST  = 5'h00;
  localparam logic [2:0]  IRQ_EN_RST   = 3'h0;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int IRQ_N       = 3;
  localparam int IRQ_CNT     = 0;
  localparam int IRQ_TIME    = 1;
  localparam int IRQ_ERR     = 2;
  localparam int CMD_W       = 12;
  localparam int CMD_ACQ_ON  = 0;
  localparam int CMD_ACQ_OFF = 1;
  localparam int CMD_LD_UTC  = 9;
  localparam int CMD_CLR_WRP = 10;
  localparam int N_CH        = 5;
  localparam int CH_MSB      = 127;
  localparam int CH_LSB      = 125;
  localparam int TS_W        = 128;
  localparam int BUF_DEPTH   = 256;
  localparam int BUF_AW      = 8;
  localparam int FIFO_DEPTH  = 16;
  localparam int POS_W       = 12;
  localparam int WRAP_W      = 20;
  localparam int ENTRY_LOG   = 4;
  localparam int CNT_W       = 9;
  localparam int SYNC_ST_W   = 10;
  localparam int SYNC_OK_BIT = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS         = 1000000;
  localparam int SEC_NS        = 1000000000;
  localparam int PLL_CFG_NS    = 1000000;
  localparam int MS_CYC        = MS_NS / CLK_PERIOD_NS;
  localparam int SEC_CYC       = SEC_NS / CLK_PERIOD_NS;
  localparam int PLL_CFG_CYC   = PLL_CFG_NS / CLK_PERIOD_NS;

  typedef enum logic {ST_INACTIVE, ST_ACTIVE} tsib_state_t;

endpackage : tsib_pkg

// *** tsib_stream_if.sv ***
// Valid/ready stream carrier between the block and its FIFO
`timescale 1ns/10ps
interface tsib_stream_if #(parameter int W = 128);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;

  modport fifo_side (input in_valid, input in_data, input out_ready,
                     output in_ready, output out_valid, output out_data);
  modport user_side (output in_valid, output in_data, output out_ready,
                     input in_ready, input out_valid, input out_data);
endinterface : tsib_stream_if
